// File: shared/mcrf_pkg.sv
// shared constants, opcodes and state type for the microcontroller core
package mcrf_pkg;
  // reset pin qualification, in clock cycles
  localparam logic [1:0] RST_LOW_CYCLES = 2'h2;
  // working register file and pointer pairs
  localparam int         REG_COUNT = 32;
  localparam logic [4:0] PTR_BASE  = 5'h1A;
  localparam logic [1:0] PTR_Z     = 2'h2;
  // linear data map
  localparam logic [7:0] REG_TOP   = 8'h1F;
  localparam logic [7:0] IO_BASE   = 8'h20;
  localparam logic [7:0] IO_TOP    = 8'h5F;
  localparam logic [7:0] SRAM_BASE = 8'h60;
  localparam logic [7:0] SRAM_TOP  = 8'hDF;
  localparam logic [5:0] SP_IO_ADDR = 6'h3D;
  // reset values
  localparam logic [7:0] SP_RESET  = 8'h00;
  // opcode field, instruction bits 15..12
  localparam logic [3:0] OP_ADD   = 4'h0;
  localparam logic [3:0] OP_SUB   = 4'h1;
  localparam logic [3:0] OP_AND   = 4'h2;
  localparam logic [3:0] OP_OR    = 4'h3;
  localparam logic [3:0] OP_EOR   = 4'h4;
  localparam logic [3:0] OP_MOV   = 4'h5;
  localparam logic [3:0] OP_LDI   = 4'h6;
  localparam logic [3:0] OP_SUBI  = 4'h7;
  localparam logic [3:0] OP_ANDI  = 4'h8;
  localparam logic [3:0] OP_ORI   = 4'h9;
  localparam logic [3:0] OP_ONE   = 4'hA;
  localparam logic [3:0] OP_RJMP  = 4'hB;
  localparam logic [3:0] OP_RCALL = 4'hC;
  localparam logic [3:0] OP_MEM   = 4'hD;
  localparam logic [3:0] OP_IO    = 4'hE;
  localparam logic [3:0] OP_SYS   = 4'hF;
  // single-register functions, bits 2..0
  localparam logic [2:0] ONE_COM = 3'h0;
  localparam logic [2:0] ONE_NEG = 3'h1;
  localparam logic [2:0] ONE_INC = 3'h2;
  localparam logic [2:0] ONE_DEC = 3'h3;
  // pointer modes, bits 8..7
  localparam logic [1:0] MODE_PLAIN = 2'h0;
  localparam logic [1:0] MODE_POST  = 2'h1;
  localparam logic [1:0] MODE_PRE   = 2'h2;
  // system functions, bits 2..0
  localparam logic [2:0] SYS_RET   = 3'h0;
  localparam logic [2:0] SYS_IJMP  = 3'h1;
  localparam logic [2:0] SYS_SLEEP = 3'h2;
  localparam logic [2:0] SYS_LPM   = 3'h3;

  typedef enum logic [3:0] {
    S_RUN, S_LD1, S_LD2, S_PUSH, S_POP1, S_POP2, S_POP3,
    S_LPM1, S_LPM2, S_IDLE, S_PDOWN
  } mcrf_state_e;
endpackage

// File: src/mcrf_core.sv
// core logic: register file, alu, data map, fetch, stack and sleep
//
// Behaviour
// RQ1 - Two low pin samples reset the core; the driver holds it that long.
// RQ2 - Thirty-two eight-bit registers are each reachable in one cycle.
// RQ3 - Two operands are read, combined and written back within one cycle.
// RQ4 - Registers 26 to 31 form three sixteen-bit data pointers.
// RQ5 - The third pointer also addresses constant bytes in program memory.
// RQ6 - Alu ops use two registers, a register and a constant, or a single one.
// RQ7 - Data addresses 0x00 to 0x1F reach the working registers.
// RQ8 - The 64 I/O locations are reached directly and at data 0x20 to 0x5F.
// RQ9 - The next word is prefetched while one executes, one per clock.
// RQ10 - Words are sixteen bits; relative jump and call reach all 1K words.
// RQ11 - Calls and interrupt entry push the return address on the sram stack.
// RQ12 - The eight-bit stack pointer is read and written through I/O space.
// RQ13 - Software loads the stack pointer before any call or interrupt.
// RQ14 - Idle sleep halts the core while memory and peripherals run on.
// RQ15 - Power-down keeps registers and stops the clock until irq or reset.
// RQ16 - Registers, I/O and 128 sram bytes share one map with five modes.
// RQ17 - Data addresses after the I/O window reach the 128 SRAM bytes.
`timescale 1ns/10ps
module mcrf_core #(
  parameter int PCW = 10
) (
  input  wire logic           mclk,
  input  wire logic           sys_rst,
  input  wire logic           rst_pin_n,
  output logic [PCW-1:0]      prog_addr_q,
  input  wire logic [15:0]    prog_data,
  output logic [6:0]          sram_addr_q,
  output logic                sram_re_q,
  output logic                sram_we_q,
  input  wire logic [7:0]     sram_rdata,
  output logic [5:0]          io_addr_q,
  output logic                io_re_q,
  output logic                io_we_q,
  input  wire logic [7:0]     io_rdata,
  output logic [7:0]          wdata_q,
  input  wire logic           irq_req,
  input  wire logic [PCW-1:0] irq_vector,
  output logic                irq_ack_q,
  input  wire logic           sleep_en,
  input  wire logic           sleep_pdown,
  output logic                cpu_halt_q,
  output logic                osc_stop_q,
  output logic                core_rst_q
);
  logic [7:0]          rf_q [mcrf_pkg::REG_COUNT];
  logic [1:0]          low_cnt_q;
  logic [PCW-1:0]      exec_pc_q, ret_q, ret_d, tgt_q, tgt_d, jmp_tgt;
  logic                valid_q, ld_io_q, ld_io_d;
  logic [15:0]         ir_q, ir_d;
  logic [7:0]          stack_pointer_q, sp_d, w1_data, wdata_d, alu_res;
  mcrf_pkg::mcrf_state_e state_q, state_d;
  logic                do_adv, do_jmp, w1_en, w2_en, irq_ack_d;
  logic [4:0]          w1_addr;
  logic                sram_re_d, sram_we_d, io_re_d, io_we_d;
  logic [6:0]          sram_addr_d;
  logic [5:0]          io_addr_d;

  // reset pin qualifier; a one-cycle glitch low never resets
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      low_cnt_q  <= 2'h0;
      core_rst_q <= 1'b1;
    end else if (rst_pin_n) begin
      low_cnt_q  <= 2'h0;
      core_rst_q <= 1'b0;
    end else begin
      if (low_cnt_q != mcrf_pkg::RST_LOW_CYCLES)
        low_cnt_q <= low_cnt_q + 2'h1;
      core_rst_q <= (low_cnt_q >= mcrf_pkg::RST_LOW_CYCLES - 2'h1); // [RQ1]
    end
  end
  wire cpu_rst = sys_rst | core_rst_q;

  // instruction fields; stalled states work from the latched word
  wire [15:0] ins   = (state_q == mcrf_pkg::S_RUN) ? prog_data : ir_q;
  wire [3:0]  op    = ins[15:12];
  wire [4:0]  rd5   = ins[9:5];
  wire [4:0]  rr5   = ins[4:0];
  wire [4:0]  rdi   = {1'b1, ins[11:8]};
  wire [1:0]  psel  = ins[11:10];
  wire [1:0]  pmode = ins[8:7];
  wire [2:0]  func  = ins[2:0];
  wire [4:0]  lpm_rd = ins[8:4];
  wire run_ex = (state_q == mcrf_pkg::S_RUN) && valid_q && !irq_req;
  wire take_irq = (state_q == mcrf_pkg::S_RUN) && valid_q && irq_req;

  // alu operand selection and result
  wire is_imm = (op >= mcrf_pkg::OP_LDI) && (op <= mcrf_pkg::OP_ORI);
  wire is_alu = (op <= mcrf_pkg::OP_ONE);
  wire [4:0] alu_dst = is_imm ? rdi : rd5;
  wire [7:0] opa = rf_q[alu_dst];                             // [RQ2] [RQ3]
  wire [7:0] opb = is_imm ? ins[7:0] : rf_q[rr5];
  always_comb begin
    case (op)                                                 // [RQ6]
      mcrf_pkg::OP_ADD:  alu_res = opa + opb;
      mcrf_pkg::OP_SUB,
      mcrf_pkg::OP_SUBI: alu_res = opa - opb;
      mcrf_pkg::OP_AND,
      mcrf_pkg::OP_ANDI: alu_res = opa & opb;
      mcrf_pkg::OP_OR,
      mcrf_pkg::OP_ORI:  alu_res = opa | opb;
      mcrf_pkg::OP_EOR:  alu_res = opa ^ opb;
      mcrf_pkg::OP_ONE: begin
        case (func)
          mcrf_pkg::ONE_COM: alu_res = ~opa;
          mcrf_pkg::ONE_NEG: alu_res = 8'h00 - opa;
          mcrf_pkg::ONE_INC: alu_res = opa + 8'h01;
          mcrf_pkg::ONE_DEC: alu_res = opa - 8'h01;
          default:           alu_res = opa;
        endcase
      end
      default:           alu_res = opb;
    endcase
  end

  // pointer pairs and effective data address
  wire [4:0]  ptr_idx = 5'(mcrf_pkg::PTR_BASE + {2'h0, psel, 1'b0}); // [RQ4]
  wire [15:0] ptr_val = {rf_q[ptr_idx + 5'h01], rf_q[ptr_idx]};
  wire [4:0]  z_idx = 5'(mcrf_pkg::PTR_BASE + {2'h0, mcrf_pkg::PTR_Z, 1'b0});
  wire [15:0] z_val = {rf_q[z_idx + 5'h01], rf_q[z_idx]};
  wire [15:0] ptr_dec = ptr_val - 16'h0001;
  wire [15:0] ptr_new = (pmode == mcrf_pkg::MODE_POST) ?
                        ptr_val + 16'h0001 : ptr_dec;
  // five modes: register, i/o direct, indirect, post-inc, pre-dec
  wire [15:0] ea16 = (op == mcrf_pkg::OP_IO) ?
      16'(ins[10:5]) + 16'(mcrf_pkg::IO_BASE) :
      ((pmode == mcrf_pkg::MODE_PRE) ? ptr_dec : ptr_val);    // [RQ16]
  wire hit_reg  = ea16 <= 16'(mcrf_pkg::REG_TOP);             // [RQ7]
  wire hit_io   = (ea16 >= 16'(mcrf_pkg::IO_BASE)) &&
                  (ea16 <= 16'(mcrf_pkg::IO_TOP));            // [RQ8]
  wire hit_sram = (ea16 >= 16'(mcrf_pkg::SRAM_BASE)) &&
                  (ea16 <= 16'(mcrf_pkg::SRAM_TOP));          // [RQ17]
  wire hit_sp   = ea16 == 16'(mcrf_pkg::IO_BASE) +
                  16'(mcrf_pkg::SP_IO_ADDR);                  // [RQ12]
  wire [4:0] ea_lo   = ea16[4:0];
  wire [5:0] io_off  = 6'(ea16 - 16'(mcrf_pkg::IO_BASE));
  wire [6:0] sram_off = 7'(ea16 - 16'(mcrf_pkg::SRAM_BASE));
  wire is_mem = (op == mcrf_pkg::OP_MEM) || (op == mcrf_pkg::OP_IO);
  wire is_st  = is_mem && ins[9 + {3'h0, op == mcrf_pkg::OP_IO} * 2];
  wire is_ld  = is_mem && !is_st;
  wire ext_io = hit_io && !hit_sp;
  wire ld_ext = is_ld && (ext_io || hit_sram);
  wire [7:0] st_data = rf_q[rr5];
  // unmapped addresses read as zero and ignore writes
  wire [7:0] int_rd = hit_reg ? rf_q[ea_lo] :
                      (hit_sp ? stack_pointer_q : 8'h00);
  wire [7:0] ext_rd = ld_io_q ? io_rdata : sram_rdata;
  wire [7:0] lpm_byte = z_val[0] ? prog_data[15:8] : prog_data[7:0];

  // jump targets and stack addresses
  wire [PCW-1:0] pc_next = exec_pc_q + PCW'(1);
  wire [PCW-1:0] rel_tgt = pc_next + PCW'($signed(ins[9:0]));  // [RQ10]
  wire [7:0] sp_inc = stack_pointer_q + 8'h01;
  wire [6:0] push_off = 7'(stack_pointer_q - mcrf_pkg::SRAM_BASE);
  wire [6:0] pop_off  = 7'(sp_inc - mcrf_pkg::SRAM_BASE);

  // sequencer; stack lives in sram, software sets its pointer first
  always_comb begin
    state_d = state_q;
    do_adv = 1'b0;
    do_jmp = 1'b0;
    jmp_tgt = tgt_q;
    w1_en = 1'b0;
    w1_addr = alu_dst;
    w1_data = alu_res;
    w2_en = 1'b0;
    sp_d = stack_pointer_q;
    sram_re_d = 1'b0;
    sram_we_d = 1'b0;
    sram_addr_d = sram_addr_q;
    io_re_d = 1'b0;
    io_we_d = 1'b0;
    io_addr_d = io_addr_q;
    wdata_d = wdata_q;
    ret_d = ret_q;
    tgt_d = tgt_q;
    ir_d = ir_q;
    ld_io_d = ld_io_q;
    irq_ack_d = 1'b0;
    case (state_q)
      mcrf_pkg::S_RUN: begin
        if (!valid_q) begin
          do_adv = 1'b1;                                      // [RQ9]
        end else if (take_irq) begin
          sram_we_d = 1'b1;                                   // [RQ11]
          sram_addr_d = push_off;
          wdata_d = exec_pc_q[7:0];
          sp_d = stack_pointer_q - 8'h01;
          ret_d = exec_pc_q;
          tgt_d = irq_vector;
          irq_ack_d = 1'b1;
          state_d = mcrf_pkg::S_PUSH;
        end else if (is_alu) begin
          w1_en = 1'b1;                                       // [RQ3]
          do_adv = 1'b1;
        end else if (op == mcrf_pkg::OP_RJMP) begin
          do_jmp = 1'b1;
          jmp_tgt = rel_tgt;
        end else if (op == mcrf_pkg::OP_RCALL) begin
          sram_we_d = 1'b1;                                   // [RQ11]
          sram_addr_d = push_off;
          wdata_d = pc_next[7:0];
          sp_d = stack_pointer_q - 8'h01;
          ret_d = pc_next;
          tgt_d = rel_tgt;
          state_d = mcrf_pkg::S_PUSH;
        end else if (is_mem) begin
          w2_en = (op == mcrf_pkg::OP_MEM) &&
                  (pmode != mcrf_pkg::MODE_PLAIN);            // [RQ4]
          w1_addr = rr5;
          w1_data = int_rd;
          io_addr_d = io_off;
          sram_addr_d = sram_off;
          wdata_d = st_data;
          if (is_st) begin
            do_adv = 1'b1;
            w1_en = hit_reg;
            w1_addr = ea_lo;
            w1_data = st_data;                                // [RQ7]
            if (hit_sp)
              sp_d = st_data;                                 // [RQ12]
            io_we_d = ext_io;                                 // [RQ8]
            sram_we_d = hit_sram;                             // [RQ17]
          end else if (ld_ext) begin
            io_re_d = ext_io;
            sram_re_d = hit_sram;
            ld_io_d = ext_io;
            ir_d = ins;
            state_d = mcrf_pkg::S_LD1;
          end else begin
            w1_en = 1'b1;
            do_adv = 1'b1;
          end
        end else begin
          case (func)
            mcrf_pkg::SYS_RET: begin
              sram_re_d = 1'b1;
              sram_addr_d = pop_off;
              sp_d = sp_inc;
              state_d = mcrf_pkg::S_POP1;
            end
            mcrf_pkg::SYS_IJMP: begin
              do_jmp = 1'b1;
              jmp_tgt = z_val[PCW-1:0];
            end
            mcrf_pkg::SYS_SLEEP: begin
              // refetch after wake, so the held fetch word is not lost
              if (sleep_en) begin
                do_jmp = 1'b1;
                jmp_tgt = pc_next;
                state_d = sleep_pdown ? mcrf_pkg::S_PDOWN :
                                        mcrf_pkg::S_IDLE;     // [RQ14]
              end else begin
                do_adv = 1'b1;
              end
            end
            mcrf_pkg::SYS_LPM: begin
              do_jmp = 1'b1;
              jmp_tgt = z_val[PCW:1];                         // [RQ5]
              ir_d = ins;
              state_d = mcrf_pkg::S_LPM1;
            end
            default: do_adv = 1'b1;
          endcase
        end
      end
      mcrf_pkg::S_LD1: state_d = mcrf_pkg::S_LD2;
      mcrf_pkg::S_LD2: begin
        w1_en = 1'b1;
        w1_addr = rr5;
        w1_data = ext_rd;
        do_adv = 1'b1;
        state_d = mcrf_pkg::S_RUN;
      end
      mcrf_pkg::S_PUSH: begin
        sram_we_d = 1'b1;                                     // [RQ11]
        sram_addr_d = push_off;
        wdata_d = 8'(ret_q >> 8);
        sp_d = stack_pointer_q - 8'h01;
        do_jmp = 1'b1;
        state_d = mcrf_pkg::S_RUN;
      end
      mcrf_pkg::S_POP1: begin
        sram_re_d = 1'b1;
        sram_addr_d = pop_off;
        sp_d = sp_inc;
        state_d = mcrf_pkg::S_POP2;
      end
      mcrf_pkg::S_POP2: begin
        tgt_d = PCW'({sram_rdata, 8'h00});
        state_d = mcrf_pkg::S_POP3;
      end
      mcrf_pkg::S_POP3: begin
        do_jmp = 1'b1;
        jmp_tgt = tgt_q | PCW'(sram_rdata);
        state_d = mcrf_pkg::S_RUN;
      end
      mcrf_pkg::S_LPM1: state_d = mcrf_pkg::S_LPM2;
      mcrf_pkg::S_LPM2: begin
        w1_en = 1'b1;
        w1_addr = lpm_rd;
        w1_data = lpm_byte;                                   // [RQ5]
        do_jmp = 1'b1;
        jmp_tgt = pc_next;
        state_d = mcrf_pkg::S_RUN;
      end
      mcrf_pkg::S_IDLE,
      mcrf_pkg::S_PDOWN: begin
        if (irq_req)
          state_d = mcrf_pkg::S_RUN;                          // [RQ15]
      end
      default: state_d = mcrf_pkg::S_RUN;
    endcase
  end

  // working registers: one write port plus the pointer pair port
  for (genvar i = 0; i < mcrf_pkg::REG_COUNT; i++) begin : g_rf
    always_ff @(posedge mclk) begin
      if (cpu_rst)
        rf_q[i] <= 8'h00;
      else if (w1_en && w1_addr == 5'(i))
        rf_q[i] <= w1_data;                                   // [RQ2]
      else if (w2_en && ptr_idx == 5'(i))
        rf_q[i] <= ptr_new[7:0];
      else if (w2_en && ptr_idx + 5'h01 == 5'(i))
        rf_q[i] <= ptr_new[15:8];
    end
  end

  // fetch pipeline; a jump costs one dead fetch slot
  always_ff @(posedge mclk) begin
    if (cpu_rst) begin
      prog_addr_q <= '0;
      exec_pc_q   <= '0;
      valid_q     <= 1'b0;
    end else if (do_jmp) begin
      prog_addr_q <= jmp_tgt;
      valid_q     <= 1'b0;
    end else if (do_adv) begin
      prog_addr_q <= prog_addr_q + PCW'(1);                   // [RQ9]
      exec_pc_q   <= prog_addr_q;
      valid_q     <= 1'b1;
    end
  end

  // sequencer state and bus strobes
  always_ff @(posedge mclk) begin
    if (cpu_rst) begin
      state_q <= mcrf_pkg::S_RUN;
      stack_pointer_q <= mcrf_pkg::SP_RESET;                  // [RQ13]
      {sram_re_q, sram_we_q, io_re_q, io_we_q} <= 4'h0;
      {sram_addr_q, io_addr_q, wdata_q} <= 21'h000000;
      {ret_q, tgt_q, ir_q, ld_io_q} <= '0;
      {irq_ack_q, cpu_halt_q, osc_stop_q} <= 3'h0;
    end else begin
      state_q <= state_d;
      stack_pointer_q <= sp_d;
      {sram_re_q, sram_we_q, io_re_q, io_we_q} <=
        {sram_re_d, sram_we_d, io_re_d, io_we_d};
      {sram_addr_q, io_addr_q, wdata_q} <= {sram_addr_d, io_addr_d, wdata_d};
      {ret_q, tgt_q, ir_q, ld_io_q} <= {ret_d, tgt_d, ir_d, ld_io_d};
      irq_ack_q  <= irq_ack_d;
      cpu_halt_q <= (state_d == mcrf_pkg::S_IDLE) ||
                    (state_d == mcrf_pkg::S_PDOWN);           // [RQ14]
      osc_stop_q <= state_d == mcrf_pkg::S_PDOWN;             // [RQ15]
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (cpu_rst);

  chk_pin_two_low: assert property (disable iff (sys_rst)   // [RQ1]
    !rst_pin_n ##1 !rst_pin_n |=> core_rst_q)
    else $error("reset pin low two cycles did not reset");
  chk_pin_glitch: assert property (disable iff (sys_rst)    // [RQ1]
    rst_pin_n ##1 !rst_pin_n ##1 rst_pin_n |-> !core_rst_q)
    else $error("single low cycle caused reset");
  chk_alu_wback: assert property (run_ex && is_alu          // [RQ3]
    |=> rf_q[$past(alu_dst)] == $past(alu_res))
    else $error("alu result not written back in one cycle");
  chk_one_per_clk: assert property (run_ex && is_alu        // [RQ9]
    |=> valid_q && exec_pc_q == $past(prog_addr_q))
    else $error("pipeline did not advance one word");
  chk_reg_window: assert property (run_ex && is_st && hit_reg // [RQ7]
    |=> rf_q[$past(ea_lo)] == $past(st_data))
    else $error("store to register space missed");
  chk_io_window: assert property (run_ex && is_st && ext_io // [RQ8]
    |=> io_we_q && io_addr_q == $past(io_off) && !sram_we_q)
    else $error("store to i/o space misrouted");
  chk_sram_window: assert property (run_ex && is_st && hit_sram // [RQ17]
    |=> sram_we_q && sram_addr_q == $past(sram_off) && !io_we_q)
    else $error("store to sram misrouted");
  chk_sp_write: assert property (run_ex && is_st && hit_sp  // [RQ12]
    |=> stack_pointer_q == $past(st_data))
    else $error("stack pointer write lost");
  chk_call_push: assert property (run_ex && op == mcrf_pkg::OP_RCALL // [RQ11]
    |=> sram_we_q ##1 sram_we_q && prog_addr_q == $past(tgt_q))
    else $error("call did not push two bytes and jump");
  chk_rel_jump: assert property (run_ex && op == mcrf_pkg::OP_RJMP // [RQ10]
    |=> prog_addr_q == $past(rel_tgt) && !valid_q)
    else $error("relative jump target wrong");
  chk_postinc: assert property (run_ex && op == mcrf_pkg::OP_MEM && // [RQ4]
    pmode == mcrf_pkg::MODE_POST && !ld_ext && rr5 < 5'h1A
    |=> {rf_q[$past(ptr_idx) + 5'h01], rf_q[$past(ptr_idx)]} ==
        $past(ptr_val) + 16'h0001)
    else $error("pointer post-increment wrong");
  chk_idle_halt: assert property (state_q == mcrf_pkg::S_IDLE // [RQ14]
    && !irq_req |-> cpu_halt_q && !osc_stop_q && !valid_q)
    else $error("idle sleep not halting core");
  chk_pdown_hold: assert property (state_q == mcrf_pkg::S_PDOWN // [RQ15]
    && !irq_req |=> osc_stop_q && $stable(stack_pointer_q))
    else $error("power-down not holding state");
  cov_irq_entry: cover property (take_irq ##2 state_q == mcrf_pkg::S_RUN);
  cov_ext_load: cover property (state_q == mcrf_pkg::S_LD2);
  cov_return: cover property (state_q == mcrf_pkg::S_POP3);
  cov_lpm: cover property (state_q == mcrf_pkg::S_LPM2);
endmodule

// File: sim/mcrf_mem_model.sv
// far-side model: program rom, data sram and i/o space
`timescale 1ns/10ps
module mcrf_mem_model (
  input  wire logic        mclk,
  input  wire logic [9:0]  prog_addr_q,
  output logic      [15:0] prog_data,
  input  wire logic [6:0]  sram_addr_q,
  input  wire logic        sram_re_q,
  input  wire logic        sram_we_q,
  output logic      [7:0]  sram_rdata,
  input  wire logic [5:0]  io_addr_q,
  input  wire logic        io_re_q,
  input  wire logic        io_we_q,
  output logic      [7:0]  io_rdata,
  input  wire logic [7:0]  wdata_q
);
  logic [15:0] rom  [0:1023];
  logic [7:0]  sram [0:127];
  logic [7:0]  io   [0:63];
  // rom answers one cycle after the address, with no stall
  always @(posedge mclk) begin
    prog_data <= rom[prog_addr_q];
    if (sram_we_q) sram[sram_addr_q] <= wdata_q;
    if (io_we_q) io[io_addr_q] <= wdata_q;
  end
  // read data stands one cycle, then inverts so a late capture shows up
  always @(posedge mclk) begin
    sram_rdata <= sram_re_q ? sram[sram_addr_q] : ~sram_rdata;
    io_rdata   <= io_re_q ? io[io_addr_q] : ~io_rdata;
  end
endmodule

// File: sim/tb_top.sv
// self-checking bench: one little program run through the core with random operands
`timescale 1ns/10ps
module tb_top;
  logic        mclk, sys_rst, rst_pin_n, irq_req, sleep_en, sleep_pdown;
  logic [9:0]  prog_addr_q, irq_vector;
  logic [15:0] prog_data;
  logic [6:0]  sram_addr_q;
  logic [5:0]  io_addr_q;
  logic [7:0]  sram_rdata, io_rdata, wdata_q, a, b, c;
  logic        sram_re_q, sram_we_q, io_re_q, io_we_q, irq_ack_q;
  logic        cpu_halt_q, osc_stop_q, core_rst_q;
  int          mismatches, checks_done, cycles, seed;

  mcrf_core DUT (.mclk(mclk), .sys_rst(sys_rst), .rst_pin_n(rst_pin_n),
    .prog_addr_q(prog_addr_q), .prog_data(prog_data),
    .sram_addr_q(sram_addr_q), .sram_re_q(sram_re_q),
    .sram_we_q(sram_we_q), .sram_rdata(sram_rdata), .io_addr_q(io_addr_q),
    .io_re_q(io_re_q), .io_we_q(io_we_q), .io_rdata(io_rdata),
    .wdata_q(wdata_q), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_ack_q(irq_ack_q), .sleep_en(sleep_en), .sleep_pdown(sleep_pdown),
    .cpu_halt_q(cpu_halt_q), .osc_stop_q(osc_stop_q),
    .core_rst_q(core_rst_q));
  mcrf_mem_model mem (.mclk(mclk), .prog_addr_q(prog_addr_q),
    .prog_data(prog_data), .sram_addr_q(sram_addr_q),
    .sram_re_q(sram_re_q), .sram_we_q(sram_we_q), .sram_rdata(sram_rdata),
    .io_addr_q(io_addr_q), .io_re_q(io_re_q), .io_we_q(io_we_q),
    .io_rdata(io_rdata), .wdata_q(wdata_q));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // instruction encoders and expected sums
  function automatic logic [15:0] ldi(input logic [4:0] r, logic [7:0] k);
    return {4'h6, r[3:0], k};
  endfunction
  function automatic logic [15:0] st(input logic [4:0] r);
    return {4'hD, 2'h0, 1'b1, 2'h1, 2'h0, r};
  endfunction
  function automatic logic [15:0] ldz(input logic [4:0] r);
    return {4'hD, 2'h2, 1'b0, 2'h0, 2'h0, r};
  endfunction
  function automatic logic [15:0] io(input logic o, logic [5:0] p,
                                     logic [4:0] r);
    return {4'hE, o, p, r};
  endfunction
  function automatic logic [7:0] add8(input logic [7:0] x, logic [7:0] y);
    return x + y;
  endfunction

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // bounded wait: 0 halt, 1 interrupt taken, 2 clock stop request
  task automatic wait_for(input int s);
    int n;
    for (n = 0; n < 200; n++) begin
      @(posedge mclk);
      #1;
      if (s == 0 && cpu_halt_q === 1'b1 || s == 1 && irq_ack_q === 1'b1 ||
          s == 2 && osc_stop_q === 1'b1) break;
    end
    chk1(n < 200, 1'b1);
  endtask

  // stack pointer is loaded before the call, as software must
  task automatic run_round;
    logic [15:0] p [0:33];
    a = 8'($random(seed));
    b = 8'($random(seed));
    c = 8'($random(seed));
    p = '{ldi(5'd16, a), ldi(5'd17, b), {6'h00, 5'd16, 5'd17},
      ldi(5'd26, 8'h60), ldi(5'd27, 8'h00), st(5'd16), ldi(5'd30, 8'h11),
      ldi(5'd31, 8'h00), ldz(5'd19), st(5'd19), ldi(5'd30, 8'h27),
      ldz(5'd20), st(5'd20), io(1'b1, 6'h05, 5'd16), ldi(5'd22, 8'hDF),
      io(1'b1, 6'h3D, 5'd22), io(1'b0, 6'h3D, 5'd23), st(5'd23), 16'hC003,
      st(5'd16), 16'hF002, 16'hF007, {6'h28, 5'd16, 5'h02}, st(5'd16),
      16'hF000,
      // handler: table byte, sram load, a jump over a poisoned word
      ldi(5'd30, 8'h00), 16'hF183, st(5'd24),
      {4'hD, 2'h0, 1'b0, 2'h2, 2'h0, 5'd25}, 16'hB001, ldi(5'd25, ~a),
      {4'h4, 2'h0, 5'd25, 5'd17}, st(5'd25), 16'hF002};
    @(posedge mclk);
    #1 sys_rst = 1'b1;
    sleep_pdown = 1'b0;
    for (int i = 0; i < 34; i++) mem.rom[i] = p[i];
    mem.io[7] = c;
    repeat (5) @(posedge mclk);
    #1 sys_rst = 1'b0;
    wait_for(0);
    chk8(mem.sram[0], add8(a, b));
    chk8(mem.sram[1], b);
    chk8(mem.sram[2], c);
    chk8(mem.io[5], add8(a, b));
    chk8(mem.sram[3], 8'hDF);
    chk8(mem.sram[4], add8(a, b) + 8'h01);
    chk8(mem.sram[5], add8(a, b) + 8'h01);
    chk8(mem.sram[127], 8'h13);
    chk8(mem.sram[126], 8'h00);
    chk1(osc_stop_q, 1'b0);
    sleep_pdown = 1'b1;
    irq_req = 1'b1;
    wait_for(1);
    irq_req = 1'b0;
    wait_for(2);
    chk1(cpu_halt_q, 1'b1);
    chk8(mem.sram[6], a ^ b);
    $display("round done a=%h b=%h c=%h", a, b, c);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      test_done;
    end
  end

  initial begin
    seed = 32'hB0E7;
    {mismatches, checks_done, cycles} = '0;
    {sys_rst, rst_pin_n, sleep_en} = 3'h7;
    {irq_req, sleep_pdown} = 2'h0;
    irq_vector = 10'h019;
    repeat (3) run_round;
    // one low sample is ignored, two low samples reset the core; the pin is then held low for three
    rst_pin_n = 1'b0;
    @(posedge mclk);
    #1 rst_pin_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk1(core_rst_q, 1'b0);
    rst_pin_n = 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk1(core_rst_q, 1'b1);
    rst_pin_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1 chk1(core_rst_q, 1'b0);
    $display("pin reset test done");
    test_done;
  end
endmodule
